// ---- common/spd_pkg.sv ----
package spd_pkg;

  // register byte offsets
  localparam logic [11:0] SPD_OFF_CTRL    = 12'h000;
  localparam logic [11:0] SPD_OFF_PERIOD  = 12'h004;
  localparam logic [11:0] SPD_OFF_LIMITS  = 12'h008;
  localparam logic [11:0] SPD_OFF_SPEED   = 12'h00C;
  localparam logic [11:0] SPD_OFF_STATUS  = 12'h010;
  localparam logic [11:0] SPD_OFF_CURPER  = 12'h014;

  // control fields
  localparam int SPD_CTRL_GATE_BIT  = 0;
  localparam int SPD_CTRL_CLEAR_BIT = 1;
  localparam int SPD_CTRL_FAST_BIT  = 2;

  // limits: low in [15:0], high in [31:16]
  localparam int SPD_LIM_LO_LSB = 0;
  localparam int SPD_LIM_HI_LSB = 16;

  localparam logic [14:0] SPD_PERIOD_MIN   = 15'h0001;
  localparam logic [14:0] SPD_PERIOD_MAX   = 15'h7FFF;
  localparam logic [14:0] SPD_PERIOD_RESET = 15'h0064;

  // period tick is 10 ms
  localparam int SPD_TICK_NS  = 10000000;
  localparam int SPD_CLK_NS   = 8;
  localparam int SPD_TICK_CYC = SPD_TICK_NS / SPD_CLK_NS;

  // least pulse spacing for each path, in ns
  localparam int SPD_SLOW_NS  = 50000000;
  localparam int SPD_FAST_NS  = 1000000;
  localparam int SPD_SLOW_CYC = SPD_SLOW_NS / SPD_CLK_NS;
  localparam int SPD_FAST_CYC = SPD_FAST_NS / SPD_CLK_NS;

  typedef struct packed {
    logic [15:0] low;
    logic [15:0] high;
  } spd_limits_t;

endpackage

// ---- core/spd_pulse_qual.sv ----
`timescale 1ns/1ps
// accepts an edge only after a minimum spacing, to model the input rate limit
module spd_pulse_qual #(
  parameter int SLOW_GAP = spd_pkg::SPD_SLOW_CYC,
  parameter int FAST_GAP = spd_pkg::SPD_FAST_CYC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic fast_sel,
  input  wire logic pulse_in,
  output logic      pulse_ok
);
  initial begin
    if (SLOW_GAP < 1 || FAST_GAP < 1) $error("spd_pulse_qual: bad gap");
  end

  typedef struct packed {
    logic        prev;
    logic [31:0] gap;
    logic        ok;
  } spd_q_st_t;

  spd_q_st_t st_r;
  spd_q_st_t st_nxt;
  logic [31:0] need;

  always_comb begin
    need        = fast_sel ? 32'(FAST_GAP) : 32'(SLOW_GAP);
    st_nxt      = st_r;
    st_nxt.prev = pulse_in;
    st_nxt.ok   = 1'b0;
    if (st_r.gap != 32'h0000_0000) begin
      st_nxt.gap = st_r.gap - 32'h0000_0001;
    end
    if (pulse_in && !st_r.prev && st_r.gap == 32'h0000_0000) begin
      st_nxt.ok  = 1'b1;
      st_nxt.gap = need - 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pulse_ok = st_r.ok;
endmodule // spd_pulse_qual

// ---- core/spd_speed_detect.sv ----
`timescale 1ns/1ps
// Behaviour
// - Frequency is found by counting pulses over a user-set period.
// - While the gate is on, each count-input pulse passed by the rate limit bumps the counter, up to 65535.
// - While the gate is off, counting and comparing stop, output holds.
// - Speed and output are kept until clear, which also zeroes counter.
// - With high above low, off at or below low, on at or above high.
// - With low above high, off at or above low, on at or below high.
// - With equal limits, output is on only when speed equals them.
// - The period setting accepts 1 to 32767 only.
// - The fast path counts pulses up to 1 kHz.
// - Only one block per program may use the fast path.
// - A dedicated clear input resets the counting state.
module spd_speed_detect #(
  parameter int TICK_CYC = spd_pkg::SPD_TICK_CYC,
  parameter int SLOW_GAP = spd_pkg::SPD_SLOW_CYC,
  parameter int FAST_GAP = spd_pkg::SPD_FAST_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        gate_in,
  input  wire logic        count_in,
  input  wire logic        clear_in,
  output logic             detect_out,
  output logic      [15:0] speed_out
);
  initial begin
    if (TICK_CYC < 1) $error("spd_speed_detect: TICK_CYC must be >= 1");
    if (FAST_GAP > SLOW_GAP) $error("spd_speed_detect: fast gap too long");
  end

  typedef struct packed {
    logic        gate_sw;
    logic        clear_sw;
    logic        fast_sel;
    logic [14:0] period;
    spd_pkg::spd_limits_t lim;
    logic [15:0] count;
    logic [14:0] elapsed;
    logic [15:0] speed;
    logic        det;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } spd_st_t;

  spd_st_t st_r;
  spd_st_t st_nxt;
  logic    tick;
  logic    pulse_ok;
  logic    gate;
  logic    clr;
  logic    wr;
  logic    wr_chk;
  logic    rd;
  logic [15:0] spd_v;

  spd_tick_div #(.DIV(TICK_CYC)) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick)
  );

  spd_pulse_qual #(.SLOW_GAP(SLOW_GAP), .FAST_GAP(FAST_GAP)) u_qual (
    .pclk     (pclk),
    .presetn  (presetn),
    .fast_sel (st_r.fast_sel),
    .pulse_in (count_in),
    .pulse_ok (pulse_ok)
  );

  assign gate = gate_in | st_r.gate_sw;
  assign clr  = clear_in | st_r.clear_sw;
  // setup cycle decodes and answers; a write lands only at the access
  // edge, so a request dropped before that edge changes nothing
  assign wr_chk = psel && !penable && pwrite;
  assign wr     = psel && penable && pwrite && st_r.pready && !st_r.pslverr;
  assign rd     = psel && !penable && !pwrite;

  always_comb begin
    st_nxt          = st_r;
    st_nxt.pready   = 1'b0;
    st_nxt.pslverr  = 1'b0;
    st_nxt.clear_sw = 1'b0;
    spd_v           = st_r.speed;

    // measurement
    if (gate) begin
      if (pulse_ok && st_r.count != 16'hFFFF) begin
        st_nxt.count = st_r.count + 16'h0001;
      end
      if (tick) begin
        if (st_r.elapsed + 15'h0001 >= st_r.period) begin
          spd_v          = (pulse_ok && st_r.count != 16'hFFFF)
                           ? st_r.count + 16'h0001 : st_r.count;
          st_nxt.speed   = spd_v;
          st_nxt.count   = 16'h0000;
          st_nxt.elapsed = 15'h0000;
        end else begin
          st_nxt.elapsed = st_r.elapsed + 15'h0001;
        end
      end
      // compare against limits
      if (st_r.lim.high > st_r.lim.low) begin
        if (st_r.speed <= st_r.lim.low) begin
          st_nxt.det = 1'b0;
        end else if (st_r.speed >= st_r.lim.high) begin
          st_nxt.det = 1'b1;
        end
      end else if (st_r.lim.low > st_r.lim.high) begin
        if (st_r.speed >= st_r.lim.low) begin
          st_nxt.det = 1'b0;
        end else if (st_r.speed <= st_r.lim.high) begin
          st_nxt.det = 1'b1;
        end
      end else begin
        st_nxt.det = (st_r.speed == st_r.lim.low);
      end
    end // gate off: measurement holds; only clear still acts

    if (clr) begin
      st_nxt.count   = 16'h0000;
      st_nxt.elapsed = 15'h0000;
      st_nxt.speed   = 16'h0000;
      st_nxt.det     = 1'b0;
    end

    // apb slave
    if (psel && !penable) begin
      st_nxt.pready = 1'b1;
      st_nxt.prdata = 32'h0000_0000;
    end
    // refusal is decided in setup so pslverr stands beside pready
    if (wr_chk) begin
      unique case (paddr)
        spd_pkg::SPD_OFF_PERIOD: begin
          if (pwdata[14:0] < spd_pkg::SPD_PERIOD_MIN
              || pwdata[31:15] != 17'h0_0000) begin
            st_nxt.pslverr = 1'b1;
          end
        end
        spd_pkg::SPD_OFF_CTRL, spd_pkg::SPD_OFF_LIMITS,
        spd_pkg::SPD_OFF_SPEED, spd_pkg::SPD_OFF_STATUS,
        spd_pkg::SPD_OFF_CURPER: begin
        end
        default: st_nxt.pslverr = 1'b1;
      endcase
    end else if (rd) begin
      unique case (paddr)
        spd_pkg::SPD_OFF_CTRL: begin
          st_nxt.prdata[spd_pkg::SPD_CTRL_GATE_BIT] = st_r.gate_sw;
          st_nxt.prdata[spd_pkg::SPD_CTRL_FAST_BIT] = st_r.fast_sel;
        end
        spd_pkg::SPD_OFF_PERIOD: st_nxt.prdata = {17'h0_0000, st_r.period};
        spd_pkg::SPD_OFF_LIMITS:
          st_nxt.prdata = {st_r.lim.high, st_r.lim.low};
        spd_pkg::SPD_OFF_SPEED:  st_nxt.prdata = {16'h0000, st_r.speed};
        spd_pkg::SPD_OFF_STATUS:
          st_nxt.prdata = {st_r.count, 15'h0000, st_r.det};
        spd_pkg::SPD_OFF_CURPER:
          st_nxt.prdata = {17'h0_0000, st_r.elapsed};
        default: st_nxt.pslverr = 1'b1;
      endcase
    end
    // refused writes never reach here: wr is gated by the setup verdict
    if (wr) begin
      unique case (paddr)
        spd_pkg::SPD_OFF_CTRL: begin
          st_nxt.gate_sw  = pwdata[spd_pkg::SPD_CTRL_GATE_BIT];
          st_nxt.clear_sw = pwdata[spd_pkg::SPD_CTRL_CLEAR_BIT];
          st_nxt.fast_sel = pwdata[spd_pkg::SPD_CTRL_FAST_BIT];
        end
        spd_pkg::SPD_OFF_PERIOD: st_nxt.period = pwdata[14:0];
        spd_pkg::SPD_OFF_LIMITS: begin
          st_nxt.lim.low  = pwdata[spd_pkg::SPD_LIM_LO_LSB +: 16];
          st_nxt.lim.high = pwdata[spd_pkg::SPD_LIM_HI_LSB +: 16];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r        <= '0;
      st_r.period <= spd_pkg::SPD_PERIOD_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata     = st_r.prdata;
  assign pready     = st_r.pready;
  assign pslverr    = st_r.pslverr;
  assign detect_out = st_r.det;
  assign speed_out  = st_r.speed;

  // pready low in setup, high for the single access cycle after it
  AST_APB_READY: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready)
    else $error("pready missing in access phase");

  // a second high cycle would let a slow master see a stale answer
  AST_APB_PULSE: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready stood longer than one cycle");

  AST_ERR_WITH_READY: assert property (
    @(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("pslverr without pready");

  AST_CLEAR: assert property (
    @(posedge pclk) disable iff (!presetn)
    clear_in |=> (speed_out == 16'h0000 && !detect_out))
    else $error("clear did not reset speed and output");

  AST_CLEAR_COUNT: assert property (
    @(posedge pclk) disable iff (!presetn)
    clr |=> (st_r.count == 16'h0000 && st_r.elapsed == 15'h0000))
    else $error("clear did not reset the counting state");

  AST_GATE_HOLD: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!gate && !clr) |=> ($stable(speed_out) && $stable(detect_out)))
    else $error("state changed while gate off");

  AST_COUNT_GATE: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!gate && !clr) |=> $stable(st_r.count))
    else $error("counter moved while gate off");

  AST_HYST_ON: assert property (
    @(posedge pclk) disable iff (!presetn)
    (gate && !clr && st_r.lim.high > st_r.lim.low
     && speed_out >= st_r.lim.high) |=> detect_out)
    else $error("output not on above high limit");

  AST_HYST_OFF: assert property (
    @(posedge pclk) disable iff (!presetn)
    (gate && !clr && st_r.lim.high > st_r.lim.low
     && speed_out <= st_r.lim.low) |=> !detect_out)
    else $error("output not off below low limit");

  AST_WIN: assert property (
    @(posedge pclk) disable iff (!presetn)
    (gate && !clr && st_r.lim.low > st_r.lim.high
     && speed_out >= st_r.lim.low) |=> !detect_out)
    else $error("output not off at or above low limit");

  AST_WIN_ON: assert property (
    @(posedge pclk) disable iff (!presetn)
    (gate && !clr && st_r.lim.low > st_r.lim.high
     && speed_out <= st_r.lim.high) |=> detect_out)
    else $error("output not on at or below high limit");

  AST_EQ: assert property (
    @(posedge pclk) disable iff (!presetn)
    (gate && !clr && st_r.lim.low == st_r.lim.high)
    |=> (detect_out == ($past(speed_out) == $past(st_r.lim.low))))
    else $error("equal-limit output wrong");

  AST_PERIOD_RANGE: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_r.period >= spd_pkg::SPD_PERIOD_MIN)
    else $error("period out of range");

  // pulse_ok excluded: a pulse on the closing tick is folded in as well
  AST_SPEED_LOAD: assert property (
    @(posedge pclk) disable iff (!presetn)
    (gate && !clr && tick && !pulse_ok
     && st_r.elapsed + 15'h0001 >= st_r.period)
    |=> (speed_out == $past(st_r.count) && st_r.count == 16'h0000))
    else $error("speed not loaded at period end");

  AST_SPEED_HOLD: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!tick && !clr) |=> $stable(speed_out))
    else $error("speed moved between period ends");

  COV_ON: cover property (@(posedge pclk) disable iff (!presetn)
    !detect_out ##1 detect_out);
  COV_SPEED: cover property (@(posedge pclk) disable iff (!presetn)
    $changed(speed_out));
  COV_CLEAR: cover property (@(posedge pclk) disable iff (!presetn)
    detect_out ##1 clear_in);
  COV_WIN: cover property (@(posedge pclk) disable iff (!presetn)
    st_r.lim.low > st_r.lim.high && detect_out);
  COV_EQ: cover property (@(posedge pclk) disable iff (!presetn)
    st_r.lim.low == st_r.lim.high && detect_out);
endmodule // spd_speed_detect

// ---- core/spd_tick_div.sv ----
`timescale 1ns/1ps
module spd_tick_div #(
  parameter int DIV = spd_pkg::SPD_TICK_CYC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      tick
);
  initial begin
    if (DIV < 1) $error("spd_tick_div: DIV must be >= 1");
  end

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } spd_div_st_t;

  spd_div_st_t st_r;
  spd_div_st_t st_nxt;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.cnt >= 32'(DIV - 1)) begin
      st_nxt.cnt  = 32'h0000_0000;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;
endmodule // spd_tick_div

// ---- dv/spd_pulse_src.sv ----
`timescale 1ns/1ps
// pulse source standing in for a controller input or a fast input
module spd_pulse_src (
  input  wire logic       pclk,
  input  wire logic       go,
  input  wire logic [7:0] num,
  input  wire logic [7:0] gap,
  output logic            pulse,
  output logic            busy
);
  logic [7:0] left_r;
  logic [7:0] wait_r;

  initial begin
    pulse  = 1'b0;
    busy   = 1'b0;
    left_r = 8'h00;
    wait_r = 8'h00;
  end

  // spacing set by the bench; below the path limit only when it says so
  always @(posedge pclk) begin
    if (go && !busy) begin
      left_r <= num;
      wait_r <= 8'h00;
      busy   <= (num != 8'h00);
    end else if (busy) begin
      if (wait_r != 8'h00) begin
        wait_r <= wait_r - 8'h01;
        pulse  <= 1'b0;
      end else if (left_r != 8'h00) begin
        pulse  <= 1'b1;
        left_r <= left_r - 8'h01;
        wait_r <= gap - 8'h01;
      end else begin
        busy <= 1'b0;
      end
    end
  end
endmodule // spd_pulse_src

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic        fast;
    logic [7:0]  gap;
    logic [7:0]  n;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [15:0] sp;
    logic        det;
  } spd_row_t;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        gate_in = 1'b0;
  logic        count_in;
  logic        clear_in = 1'b0;
  logic        detect_out;
  logic [15:0] speed_out;
  logic        src_go = 1'b0;
  logic [7:0]  src_num = 8'h00;
  logic [7:0]  src_gap = 8'h02;
  logic        src_busy;
  logic [31:0] rd;
  logic        err;
  int          mismatches = 0;
  int          tests_run = 0;
  spd_row_t    rows [9];

  always #4 pclk = ~pclk;

  spd_speed_detect #(.TICK_CYC(10), .SLOW_GAP(4), .FAST_GAP(2)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .gate_in(gate_in),
    .count_in(count_in), .clear_in(clear_in), .detect_out(detect_out),
    .speed_out(speed_out));

  spd_pulse_src src (.pclk(pclk), .go(src_go), .num(src_num),
    .gap(src_gap), .pulse(count_in), .busy(src_busy));

  task automatic final_report;
    if (mismatches == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle limit here: the watchdog ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pulses(input logic [7:0] n, input logic [7:0] g);
    int i;
    src_go  <= 1'b1;
    src_num <= n;
    src_gap <= g;
    @(posedge pclk);
    src_go <= 1'b0;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (src_busy && i < 400);
    repeat (3) @(posedge pclk);
  endtask

  task automatic lim(input logic [15:0] hi, input logic [15:0] lo,
                     input logic e);
    apb(1'b1, spd_pkg::SPD_OFF_LIMITS, {hi, lo});
    repeat (2) @(posedge pclk);
    chk({31'h0, detect_out}, {31'h0, e});
  endtask

  initial begin
    repeat (30000) @(posedge pclk);
    mismatches++;
    final_report();
  end

  initial begin
    int i;
    rows[0] = '{1'b0, 8'h06, 8'h02, 16'h2, 16'h4, 16'h2, 1'b0};
    rows[1] = '{1'b0, 8'h06, 8'h03, 16'h2, 16'h4, 16'h3, 1'b0};
    rows[2] = '{1'b0, 8'h06, 8'h01, 16'h4, 16'h2, 16'h1, 1'b1};
    rows[3] = '{1'b0, 8'h06, 8'h04, 16'h4, 16'h2, 16'h4, 1'b0};
    rows[4] = '{1'b0, 8'h06, 8'h03, 16'h3, 16'h3, 16'h3, 1'b1};
    rows[5] = '{1'b0, 8'h06, 8'h02, 16'h3, 16'h3, 16'h2, 1'b0};
    rows[6] = '{1'b0, 8'h02, 8'h04, 16'h9, 16'h9, 16'h2, 1'b0};
    rows[7] = '{1'b1, 8'h02, 8'h04, 16'h9, 16'h9, 16'h4, 1'b0};
    rows[8] = '{1'b0, 8'h06, 8'h05, 16'h2, 16'h4, 16'h5, 1'b1};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, spd_pkg::SPD_OFF_PERIOD, 32'h0);
    chk(rd, 32'h64);
    apb(1'b0, spd_pkg::SPD_OFF_SPEED, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h018, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, spd_pkg::SPD_OFF_PERIOD, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, spd_pkg::SPD_OFF_PERIOD, 32'h8000);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, spd_pkg::SPD_OFF_PERIOD, 32'h7FFF);
    apb(1'b0, spd_pkg::SPD_OFF_PERIOD, 32'h0);
    chk(rd, 32'h7FFF);
    apb(1'b1, spd_pkg::SPD_OFF_PERIOD, 32'h64);
    foreach (rows[k]) begin
      apb(1'b1, spd_pkg::SPD_OFF_LIMITS, {rows[k].hi, rows[k].lo});
      apb(1'b1, spd_pkg::SPD_OFF_CTRL, {29'h0, rows[k].fast, 2'b11});
      apb(1'b1, spd_pkg::SPD_OFF_CTRL, {29'h0, rows[k].fast, 2'b01});
      pulses(rows[k].n, rows[k].gap);
      apb(1'b0, spd_pkg::SPD_OFF_STATUS, 32'h0);
      chk(rd[31:16], {16'h0, rows[k].sp});
      // short period forces a load at the next tick
      apb(1'b1, spd_pkg::SPD_OFF_PERIOD, 32'h1);
      i = 0;
      do begin
        @(posedge pclk);
        i++;
      end while (speed_out === 16'h0000 && i < 14);
      apb(1'b1, spd_pkg::SPD_OFF_PERIOD, 32'h64);
      chk({16'h0, speed_out}, {16'h0, rows[k].sp});
      chk({31'h0, detect_out}, {31'h0, rows[k].det});
    end
    lim(16'h9, 16'h1, 1'b1);
    lim(16'h9, 16'h6, 1'b0);
    lim(16'h5, 16'h9, 1'b1);
    lim(16'h3, 16'h9, 1'b1);
    lim(16'h3, 16'h5, 1'b0);
    apb(1'b1, spd_pkg::SPD_OFF_CTRL, 32'h0);
    lim(16'h2, 16'h1, 1'b0);
    pulses(8'h03, 8'h06);
    apb(1'b0, spd_pkg::SPD_OFF_STATUS, 32'h0);
    chk(rd, 32'h0);
    gate_in <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({31'h0, detect_out}, 32'h1);
    chk({16'h0, speed_out}, 32'h5);
    clear_in <= 1'b1;
    @(posedge pclk);
    clear_in <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({16'h0, speed_out}, 32'h0);
    chk({31'h0, detect_out}, 32'h0);
    // mid-run reset: output and period return to reset values
    apb(1'b1, spd_pkg::SPD_OFF_LIMITS, {16'h1, 16'h2});
    apb(1'b1, spd_pkg::SPD_OFF_PERIOD, 32'h20);
    chk({31'h0, detect_out}, 32'h1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({31'h0, detect_out}, 32'h0);
    presetn <= 1'b1;
    // gate_in still high: elapsed is 2 after 21 to 30 cycles
    repeat (25) @(posedge pclk);
    apb(1'b0, spd_pkg::SPD_OFF_CURPER, 32'h0);
    chk(rd, 32'h2);
    apb(1'b0, spd_pkg::SPD_OFF_PERIOD, 32'h0);
    chk(rd, 32'h64);
    final_report();
  end
endmodule // tb_top
